// File: shared/clkgen_defs.svh
// Constants of the switching-clock generator: offsets, fields, timing.
// Assumes a 125 MHz system clock and an APB master with 32-bit data.
`ifndef CLKGEN_DEFS_SVH
`define CLKGEN_DEFS_SVH

// ****************************************************************
// Clock and frequencies
// ****************************************************************
`define CLK_FREQUENCY_SET_PIN_KHZ 125000
`define CLK_FREQUENCY_SET_PIN_HZ 125000000
`define F_LOW_0_KHZ 320
`define F_LOW_1_KHZ 360
`define F_LOW_2_KHZ 400
`define F_LOW_DEF_KHZ 440
`define F_LOW_3_KHZ 480
`define F_LOW_4_KHZ 520
`define F_LOW_5_KHZ 560
`define F_HIGH_0_KHZ 1600
`define F_HIGH_1_KHZ 1800
`define F_HIGH_2_KHZ 2000
`define F_HIGH_DEF_KHZ 2200
`define F_HIGH_3_KHZ 2400
`define F_HIGH_4_KHZ 2600
`define F_HIGH_5_KHZ 2800

// ****************************************************************
// Resistor class codes on the frequency-set pin
// ****************************************************************
`define FSET_GND 4'h0
`define FSET_2K2 4'h1
`define FSET_3K3 4'h2
`define FSET_4K7 4'h3
`define FSET_6K8 4'h4
`define FSET_10K 4'h5
`define FSET_15K 4'h6
`define FSET_22K 4'h7
`define FSET_33K 4'h8
`define FSET_47K 4'h9
`define FSET_68K 4'hA
`define FSET_100K 4'hB
`define FSET_150K 4'hC
`define FSET_OPEN 4'hF

// ****************************************************************
// Synchronization capture ranges and acceptance
// ****************************************************************
`define SYNC_LF_MIN_KHZ 320
`define SYNC_LF_MAX_KHZ 560
`define SYNC_HF_MIN_KHZ 1600
`define SYNC_HF_MAX_KHZ 2800
`define SYNC_MARGIN_CYC 2
`define SYNC_ACCEPT_EDGES 4

// ****************************************************************
// Spread spectrum
// ****************************************************************
`define SS_MOD_HZ 8300
`define SS_RANGE_PERMILLE 75
`define SS_STEPS 512
`define SS_TICK_CYC (`CLK_FREQUENCY_SET_PIN_HZ / (`SS_MOD_HZ * `SS_STEPS))

// ****************************************************************
// APB register map
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_PERIOD 8'h08
`define CTRL_SYNC_BIT 0
`define CTRL_SPREAD_BIT 1
`define CTRL_RESET 2'h3

`endif

// File: shared/clkgen_pkg.sv
// Types of the switching-clock generator.
// Assumes clkgen_defs.svh for all numeric constants.
package clkgen_pkg;

    typedef enum logic {SYNC_HUNT, SYNC_LOCKED} sync_state_e;

    typedef struct packed {
        logic [3:0] code;
        logic latched;
        logic highRange;
        logic [15:0] basePeriod;
        logic [15:0] spanMax;
        logic [15:0] periodCnt;
        logic [15:0] periodLen;
        logic [15:0] syncGap;
        logic [2:0] syncGood;
        sync_state_e syncState;
        logic syncLvlPrev;
        logic [7:0] triPos;
        logic triDown;
        logic [7:0] triTick;
        logic highSide;
        logic lowSide;
        logic periodStart;
        logic [1:0] ctrl;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } clkgen_state_s;

    typedef struct packed {
        logic [1:0] rstPipe;
        logic toggle;
    } edge_state_s;

endpackage : clkgen_pkg

// File: logic/level_sync.sv
// Three-flop synchroniser for pins and foreign-clock levels.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Levels
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] stable
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] out;
    } sync_state_s;

    sync_state_s st_r;
    sync_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = async;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // Bit changes only when second and third flops agree
        for (int i = 0; i < WIDTH; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.out[i] = st_r.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '{s1: INIT, s2: INIT, s3: INIT, out: INIT};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign stable = st_r.out;
endmodule : level_sync

// File: logic/sync_edge_toggle.sv
// Link-domain logic: flips a toggle on each falling sync clock edge after the first two since reset.
// Assumes the sync clock may stop; receiver only watches for changes.
`timescale 1ns/1ps
module sync_edge_toggle (
    // Link clock and system reset
    input wire logic syncClk,
    input wire logic rst_b,
    // Event toggle towards the system domain
    output logic edgeToggle
);
    clkgen_pkg::edge_state_s st_r;
    clkgen_pkg::edge_state_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.rstPipe = {st_r.rstPipe[0], 1'b1};
        if (st_r.rstPipe[1]) begin
            st_nxt.toggle = ~st_r.toggle;
        end
    end

    // Falling edge marks the start of a synchronized period
    always_ff @(negedge syncClk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign edgeToggle = st_r.toggle;
endmodule : sync_edge_toggle

// File: logic/switching_clock_generator.sv
// Switching-clock generator: frequency select, sync lock, spread spectrum.
// Assumes startupDone and pwmMode come from the regulator's sequencer
// on clk; pins and the sync clock are asynchronous to clk.
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module switching_clock_generator (
    // System clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Regulator sequencing
    input wire logic regEnable,
    input wire logic startupDone,
    input wire logic pwmMode,
    // Configuration pins
    input wire logic [3:0] frequencySetPin,
    input wire logic spreadEnablePin,
    // External synchronization clock
    input wire logic syncClk,
    // Power stage timing
    output logic highSideOn,
    output logic lowSideOn,
    output logic periodStart
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic [15:0] cyclesOf(input int fKhz);
        cyclesOf = 16'(`CLK_FREQUENCY_SET_PIN_KHZ / fKhz);
    endfunction : cyclesOf

    function automatic logic [15:0] periodOf(input logic [3:0] code);
        case (code)
            `FSET_GND: periodOf = cyclesOf(`F_LOW_DEF_KHZ);
            `FSET_2K2: periodOf = cyclesOf(`F_LOW_0_KHZ);
            `FSET_3K3: periodOf = cyclesOf(`F_LOW_1_KHZ);
            `FSET_4K7: periodOf = cyclesOf(`F_LOW_2_KHZ);
            `FSET_6K8: periodOf = cyclesOf(`F_LOW_3_KHZ);
            `FSET_10K: periodOf = cyclesOf(`F_LOW_4_KHZ);
            `FSET_15K: periodOf = cyclesOf(`F_LOW_5_KHZ);
            `FSET_22K: periodOf = cyclesOf(`F_HIGH_0_KHZ);
            `FSET_33K: periodOf = cyclesOf(`F_HIGH_1_KHZ);
            `FSET_47K: periodOf = cyclesOf(`F_HIGH_2_KHZ);
            `FSET_68K: periodOf = cyclesOf(`F_HIGH_3_KHZ);
            `FSET_100K: periodOf = cyclesOf(`F_HIGH_4_KHZ);
            `FSET_150K: periodOf = cyclesOf(`F_HIGH_5_KHZ);
            default: periodOf = cyclesOf(`F_HIGH_DEF_KHZ);
        endcase
    endfunction : periodOf

    function automatic logic isHigh(input logic [3:0] code);
        isHigh = (code >= `FSET_22K);
    endfunction : isHigh

    function automatic logic [15:0] spanOf(input logic [15:0] per);
        logic [31:0] prod;
        prod = 32'(per) * 32'(`SS_RANGE_PERMILLE);
        spanOf = 16'(prod / 32'd1000);
    endfunction : spanOf

    // ****************************************************************
    // Input crossings
    // ****************************************************************
    logic syncToggle;
    logic syncLvl;
    logic [3:0] fsetSync;
    logic spreadPinSync;

    sync_edge_toggle edgeCapture (
        .syncClk(syncClk),
        .rst_b(rst_b),
        .edgeToggle(syncToggle)
    );

    level_sync #(.WIDTH(1), .INIT(1'b0)) syncLevel (
        .clk(clk),
        .rst_b(rst_b),
        .async(syncToggle),
        .stable(syncLvl)
    );

    level_sync #(.WIDTH(5), .INIT(5'h0F)) pinLevel (
        .clk(clk),
        .rst_b(rst_b),
        .async({spreadEnablePin, frequencySetPin}),
        .stable({spreadPinSync, fsetSync})
    );

    // ****************************************************************
    // State
    // ****************************************************************
    clkgen_pkg::clkgen_state_s st_r;
    clkgen_pkg::clkgen_state_s st_nxt;

    logic syncEdge;
    logic syncAllowed;
    logic inRange;
    logic timedOut;
    logic locked;
    logic spreadOn;
    logic periodEnd;
    logic [15:0] minGap;
    logic [15:0] maxGap;
    logic [15:0] nextLen;
    logic [24:0] devScaled;
    logic apbAccess;
    logic [31:0] rdData;
    logic rdErr;

    always_comb begin
        st_nxt = st_r;
        st_nxt.periodStart = 1'b0;

        // ************************************************************
        // Frequency selection, taken during startup only
        // ************************************************************
        if (!regEnable) begin
            st_nxt.latched = 1'b0;
        end else if (!st_r.latched) begin
            st_nxt.code = fsetSync;
            st_nxt.highRange = isHigh(fsetSync);
            st_nxt.basePeriod = periodOf(fsetSync);
            st_nxt.spanMax = spanOf(periodOf(fsetSync));
            st_nxt.latched = startupDone;
        end

        // ************************************************************
        // Sync edge timing and acceptance
        // ************************************************************
        syncEdge = (syncLvl != st_r.syncLvlPrev);
        st_nxt.syncLvlPrev = syncLvl;
        if (st_r.highRange) begin
            minGap = cyclesOf(`SYNC_HF_MAX_KHZ) - 16'(`SYNC_MARGIN_CYC);
            maxGap = cyclesOf(`SYNC_HF_MIN_KHZ) + 16'(`SYNC_MARGIN_CYC);
        end else begin
            minGap = cyclesOf(`SYNC_LF_MAX_KHZ) - 16'(`SYNC_MARGIN_CYC);
            maxGap = cyclesOf(`SYNC_LF_MIN_KHZ) + 16'(`SYNC_MARGIN_CYC);
        end
        inRange = (st_r.syncGap >= minGap) && (st_r.syncGap <= maxGap);
        timedOut = (st_r.syncGap > maxGap);
        if (syncEdge) begin
            st_nxt.syncGap = 16'h0001;
        end else if (st_r.syncGap != 16'hFFFF) begin
            st_nxt.syncGap = st_r.syncGap + 16'h0001;
        end

        syncAllowed = st_r.latched && pwmMode && st_r.ctrl[`CTRL_SYNC_BIT];
        case (st_r.syncState)
            clkgen_pkg::SYNC_HUNT: begin
                if (!syncAllowed) begin
                    st_nxt.syncGood = 3'h0;
                end else if (syncEdge) begin
                    if (!inRange) begin
                        st_nxt.syncGood = 3'h0;
                    end else if (st_r.syncGood ==
                                 3'(`SYNC_ACCEPT_EDGES - 1)) begin
                        st_nxt.syncState = clkgen_pkg::SYNC_LOCKED;
                        st_nxt.syncGood = 3'h0;
                    end else begin
                        st_nxt.syncGood = st_r.syncGood + 3'h1;
                    end
                end
            end
            clkgen_pkg::SYNC_LOCKED: begin
                if (!syncAllowed || timedOut || (syncEdge && !inRange)) begin
                    st_nxt.syncState = clkgen_pkg::SYNC_HUNT;
                end
            end
            default: begin
                st_nxt.syncState = clkgen_pkg::SYNC_HUNT;
            end
        endcase
        locked = (st_r.syncState == clkgen_pkg::SYNC_LOCKED);

        // ************************************************************
        // Triangle spread-spectrum profile
        // ************************************************************
        spreadOn = pwmMode && !locked && st_r.latched
                   && spreadPinSync && st_r.ctrl[`CTRL_SPREAD_BIT];
        if (!spreadOn) begin
            st_nxt.triTick = 8'h00;
            st_nxt.triPos = 8'h80;
            st_nxt.triDown = 1'b0;
        end else if (st_r.triTick == 8'(`SS_TICK_CYC - 1)) begin
            st_nxt.triTick = 8'h00;
            if (st_r.triDown) begin
                st_nxt.triPos = st_r.triPos - 8'h01;
                st_nxt.triDown = (st_r.triPos != 8'h01);
            end else begin
                st_nxt.triPos = st_r.triPos + 8'h01;
                st_nxt.triDown = (st_r.triPos == 8'hFE);
            end
        end else begin
            st_nxt.triTick = st_r.triTick + 8'h01;
        end
        devScaled = 25'(st_r.triPos) * 25'({st_r.spanMax, 1'b0});
        if (spreadOn) begin
            nextLen = st_r.basePeriod - st_r.spanMax
                      + devScaled[23:8];
        end else begin
            nextLen = st_r.basePeriod;
        end

        // ************************************************************
        // Switching period counter
        // ************************************************************
        periodEnd = (st_r.periodCnt + 16'h0001 >= st_r.periodLen);
        if (locked ? syncEdge : periodEnd) begin
            st_nxt.periodCnt = 16'h0000;
            st_nxt.periodLen = nextLen;
            st_nxt.periodStart = regEnable && pwmMode;
        end else if (st_r.periodCnt != 16'hFFFF) begin
            st_nxt.periodCnt = st_r.periodCnt + 16'h0001;
        end
        st_nxt.highSide = regEnable && pwmMode
                          && (st_nxt.periodCnt < {1'b0, st_nxt.periodLen[15:1]});
        st_nxt.lowSide = regEnable && pwmMode && !st_nxt.highSide;

        // ************************************************************
        // APB slave, one wait state
        // ************************************************************
        apbAccess = psel && penable;
        rdErr = 1'b0;
        case (paddr)
            `REG_CTRL: rdData = {30'h0, st_r.ctrl};
            `REG_STATUS: rdData = {24'h0000_00, spreadOn, locked,
                                   st_r.latched, st_r.highRange, st_r.code};
            `REG_PERIOD: rdData = {16'h0000, st_r.periodLen};
            default: begin
                rdData = 32'h0000_0000;
                rdErr = 1'b1;
            end
        endcase
        st_nxt.pready = apbAccess && !st_r.pready;
        // Error flag stands with pready only
        st_nxt.pslverr = apbAccess && !st_r.pready && rdErr;
        if (apbAccess && !st_r.pready) begin
            st_nxt.prdata = pwrite ? 32'h0000_0000 : rdData;
        end
        if (apbAccess && st_r.pready && pwrite && !st_r.pslverr
            && paddr == `REG_CTRL && pstrb[0]) begin
            st_nxt.ctrl = pwdata[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.ctrl <= `CTRL_RESET;
            st_r.code <= `FSET_OPEN;
            st_r.highRange <= 1'b1;
            st_r.basePeriod <= 16'h0038;
            st_r.periodLen <= 16'h0038;
            st_r.triPos <= 8'h80;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign highSideOn = st_r.highSide;
    assign lowSideOn = st_r.lowSide;
    assign periodStart = st_r.periodStart;
endmodule : switching_clock_generator

// File: tb/sync_osc_model.sv
// Partner model: the external synchronization oscillator.
// Assumes the bench sets run and both half periods in ns.
`timescale 1ns/1ps
module sync_osc_model (
    // Control from the bench
    input wire logic run,
    input wire logic [15:0] highNs,
    input wire logic [15:0] lowNs,
    // Link clock
    output logic syncClk
);
    // Stands low between frames, finishes a started period
    initial begin
        syncClk = 1'b0;
        forever begin
            wait (run);
            syncClk = 1'b1;
            #(highNs);
            syncClk = 1'b0;
            #(lowNs);
        end
    end
endmodule : sync_osc_model

// File: tb/switching_clock_generator_asserts.sv
// Port checker of the switching-clock generator, bound to its top.
// Assumes every watched port belongs to the clk domain.
`timescale 1ns/1ps
module switching_clock_generator_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencing and stages
    input wire logic regEnable,
    input wire logic pwmMode,
    input wire logic highSideOn,
    input wire logic lowSideOn,
    input wire logic periodStart
);
    int gapCnt_r;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Cycles since the last period start while switching
    always_ff @(posedge clk) begin
        if (!rst_b || periodStart || !(regEnable && pwmMode)) begin
            gapCnt_r <= 0;
        end else begin
            gapCnt_r <= gapCnt_r + 1;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("APB access not answered after one wait state");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    ready_cause_a: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    error_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr outside a completion");
    stages_off_a: assert property (
        !(regEnable && pwmMode) |=> !highSideOn && !lowSideOn && !periodStart)
        else $error("stages switching outside PWM operation");
    stages_excl_a: assert property (!(highSideOn && lowSideOn))
        else $error("both power stages on together");
    stage_one_a: assert property (
        regEnable && pwmMode |=> highSideOn != lowSideOn)
        else $error("no power stage on while switching");
    start_pulse_a: assert property (periodStart |=> !periodStart)
        else $error("period start longer than one cycle");
    start_high_a: assert property (periodStart |-> ##[0:1] highSideOn)
        else $error("period start without high side on");
    period_bound_a: assert property (gapCnt_r < 900)
        else $error("switching stalled beyond one period");

    cover property (pready && pslverr);
    cover property (pready && !pwrite);
    cover property (regEnable && pwmMode ##1 periodStart);
endmodule : switching_clock_generator_asserts

bind switching_clock_generator switching_clock_generator_asserts chk (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .regEnable(regEnable), .pwmMode(pwmMode), .highSideOn(highSideOn),
    .lowSideOn(lowSideOn), .periodStart(periodStart));

// File: tb/test_switching_clock_generator.sv
// Bench of the switching-clock generator: APB, pins and sync clock.
// Assumes the oscillator model and the bound port checker.
`timescale 1ns/1ps
`include "clkgen_defs.svh"
module test_switching_clock_generator;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic regEnable = 1'b0;
    logic startupDone = 1'b0;
    logic pwmMode = 1'b1;
    logic [3:0] frequencySetPin = 4'h0;
    logic spreadEnablePin = 1'b0;
    logic syncRun = 1'b1;
    logic [15:0] syncHigh = 16'h0010;
    logic [15:0] syncLow = 16'h0010;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic syncClk;
    logic highSideOn;
    logic lowSideOn;
    logic periodStart;
    int error_cnt = 0;
    int check_count = 0;
    int base = `CLK_FREQUENCY_SET_PIN_KHZ / `F_LOW_DEF_KHZ;

    always #4 clk = ~clk;

    sync_osc_model osc (.run(syncRun), .highNs(syncHigh), .lowNs(syncLow),
        .syncClk(syncClk));
    switching_clock_generator uut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .regEnable(regEnable), .startupDone(startupDone), .pwmMode(pwmMode),
        .frequencySetPin(frequencySetPin),
        .spreadEnablePin(spreadEnablePin), .syncClk(syncClk),
        .highSideOn(highSideOn), .lowSideOn(lowSideOn),
        .periodStart(periodStart));

    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        check("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdreg(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rdreg

    task automatic wait_start(output int n);
        n = 0;
        while (periodStart !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("start seen", periodStart, 1'b1);
    endtask : wait_start

    task automatic measure(output int n, output int hi);
        wait_start(n);
        n = 0;
        hi = 0;
        do begin
            hi += (highSideOn === 1'b1);
            n++;
            @(posedge clk);
        end while (periodStart !== 1'b1 && n < 1000);
    endtask : measure

    task automatic startup(input logic [3:0] code);
        @(posedge clk);
        regEnable <= 1'b0;
        startupDone <= 1'b0;
        frequencySetPin <= code;
        cyc(3);
        regEnable <= 1'b1;
        cyc(8);
        startupDone <= 1'b1;
        cyc(4);
    endtask : startup

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rdreg(`REG_CTRL);
        check("ctrl reset", rd, 32'h0000_0003);
        apb(1'b1, `REG_CTRL, 32'h0000_0000, 4'h0);
        apb(1'b1, `REG_STATUS, 32'h0000_00FF, 4'hF);
        rdreg(`REG_CTRL);
        check("ctrl lane off", rd, 32'h0000_0003);
        apb(1'b1, `REG_CTRL, 32'h0000_0001, 4'hF);
        rdreg(`REG_CTRL);
        check("ctrl write", rd, 32'h0000_0001);
        check("mapped ok", err, 1'b0);
        rdreg(8'h0C);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0000_0000);
        apb(1'b1, `REG_CTRL, 32'h0000_0003, 4'hF);
    endtask : t_regs

    task automatic t_frequency_set_pin();
        int khz [16] = '{`F_LOW_DEF_KHZ, `F_LOW_0_KHZ, `F_LOW_1_KHZ,
            `F_LOW_2_KHZ, `F_LOW_3_KHZ, `F_LOW_4_KHZ, `F_LOW_5_KHZ,
            `F_HIGH_0_KHZ, `F_HIGH_1_KHZ, `F_HIGH_2_KHZ, `F_HIGH_3_KHZ,
            `F_HIGH_4_KHZ, `F_HIGH_5_KHZ, `F_HIGH_DEF_KHZ,
            `F_HIGH_DEF_KHZ, `F_HIGH_DEF_KHZ};
        int n;
        for (int i = 0; i < 16; i++) begin
            startup(4'(i));
            wait_start(n);
            rdreg(`REG_PERIOD);
            check("period", rd, `CLK_FREQUENCY_SET_PIN_KHZ / khz[i]);
            rdreg(`REG_STATUS);
            check("status", rd[5:0], {1'b1, i > 6, i[3:0]});
        end
        frequencySetPin <= 4'h0;
        cyc(20);
        wait_start(n);
        rdreg(`REG_PERIOD);
        check("frozen", rd, `CLK_FREQUENCY_SET_PIN_KHZ / `F_HIGH_DEF_KHZ);
    endtask : t_frequency_set_pin

    task automatic t_period();
        int n;
        int hi;
        startup(`FSET_GND);
        measure(n, hi);
        check("period len", n, base);
        check("high half", hi, base / 2);
        pwmMode <= 1'b0;
        cyc(3);
        n = 0;
        repeat (600) begin
            @(posedge clk);
            n += ((periodStart | highSideOn | lowSideOn) !== 1'b0);
        end
        check("quiet", n, 0);
        pwmMode <= 1'b1;
    endtask : t_period

    task automatic t_sync();
        int n;
        int hi;
        @(posedge clk);
        syncHigh <= 16'h04DF;
        syncLow <= 16'h04E5;
        syncRun <= 1'b1;
        startupDone <= 1'b0;
        regEnable <= 1'b0;
        frequencySetPin <= `FSET_GND;
        cyc(3);
        regEnable <= 1'b1;
        cyc(2500);
        rdreg(`REG_STATUS);
        check("lock early", rd[6], 1'b0);
        startupDone <= 1'b1;
        cyc(2500);
        rdreg(`REG_STATUS);
        check("locked", rd[6], 1'b1);
        @(negedge syncClk);
        wait_start(n);
        check("sync phase", n < 9, 1'b1);
        measure(n, hi);
        check("sync period", n > 310 && n < 315, 1'b1);
        spreadEnablePin <= 1'b1;
        cyc(100);
        rdreg(`REG_STATUS);
        check("no spread", rd[7], 1'b0);
        spreadEnablePin <= 1'b0;
        pwmMode <= 1'b0;
        cyc(10);
        rdreg(`REG_STATUS);
        check("pfm unlock", rd[6], 1'b0);
        pwmMode <= 1'b1;
        cyc(2500);
        syncRun <= 1'b0;
        cyc(800);
        rdreg(`REG_STATUS);
        check("lost", rd[6], 1'b0);
        measure(n, hi);
        check("fallback", n, base);
        syncHigh <= 16'h0010;
        syncLow <= 16'h0010;
        syncRun <= 1'b1;
        cyc(2000);
        rdreg(`REG_STATUS);
        check("fast no lock", rd[6], 1'b0);
        measure(n, hi);
        check("fast period", n, base);
        syncRun <= 1'b0;
    endtask : t_sync

    task automatic t_spread();
        int span;
        int mn;
        int mx;
        span = base * `SS_RANGE_PERMILLE / 1000;
        mn = 9999;
        mx = 0;
        startup(`FSET_GND);
        spreadEnablePin <= 1'b1;
        cyc(10);
        rdreg(`REG_STATUS);
        check("spread on", rd[7], 1'b1);
        apb(1'b1, `REG_CTRL, 32'h0000_0001, 4'hF);
        rdreg(`REG_STATUS);
        check("ctrl spread off", rd[7], 1'b0);
        apb(1'b1, `REG_CTRL, 32'h0000_0003, 4'hF);
        repeat (150) begin
            rdreg(`REG_PERIOD);
            mn = (int'(rd) < mn) ? int'(rd) : mn;
            mx = (int'(rd) > mx) ? int'(rd) : mx;
            cyc(95);
        end
        check("spread min", $unsigned(mn - (base - span)) < 4, 1'b1);
        check("spread max",
            $unsigned(base - span + 255 * 2 * span / 256 - mx) < 4,
            1'b1);
        spreadEnablePin <= 1'b0;
        cyc(600);
        rdreg(`REG_PERIOD);
        check("spread off", rd, base);
    endtask : t_spread

    initial begin
        #600_000;
        error_cnt++;
        $display("BAD watchdog expected done seen hang");
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        syncRun <= 1'b0;
        t_regs();
        t_frequency_set_pin();
        t_period();
        t_sync();
        t_spread();
        give_verdict();
    end
endmodule : test_switching_clock_generator
